// file: core/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
	// ============================================================
	// Register map
	localparam logic [7:0] global_irq_enable_addr = 8'h20;
	localparam logic [7:0] endpoint_irq_enable_addr = 8'h21;
	localparam logic [7:0] proc_status_addr = 8'hFF;
	localparam logic [7:0] global_en_reset = 8'h00;
	localparam logic [7:0] endpoint_en_reset = 8'h00;
	localparam logic [7:0] global_en_mask = 8'h6F;
	localparam logic [7:0] endpoint_en_mask = 8'h1F;
	localparam int status_gie_bit = 2;
	localparam int status_pending_bit = 7;
	// ============================================================
	// Sources, one bit each, vector number minus one
	localparam int num_sources = 12;
	localparam int src_bus_reset = 0;
	localparam int src_timer_128us = 1;
	localparam int src_timer_1ms = 2;
	localparam int src_addr_a_ep0 = 3;
	localparam int src_addr_a_ep1 = 4;
	localparam int src_addr_a_ep2 = 5;
	localparam int src_addr_b_ep0 = 6;
	localparam int src_addr_b_ep1 = 7;
	localparam int src_hub = 8;
	localparam int src_dac = 9;
	localparam int src_gpio = 10;
	localparam int src_i2c = 11;
	// Global enable bit positions
	localparam int gen_bus_reset = 0;
	localparam int gen_timer_128us = 1;
	localparam int gen_timer_1ms = 2;
	localparam int gen_hub = 3;
	localparam int gen_gpio = 5;
	localparam int gen_i2c = 6;
	localparam int ep_en_count = 5;
	// ============================================================
	// Vector table and timing
	localparam logic [15:0] reset_vector = 16'h0000;
	localparam logic [15:0] vector_base = 16'h0002;
	localparam logic [15:0] vector_stride = 16'h0002;
	localparam int call_cycles = 10;
	localparam int jump_cycles = 5;
	localparam int seq_cnt_w = 4;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef struct packed {
		logic [15:0] pc;
		logic carry_flag;
		logic zero_flag;
	} stack_frame_t;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_call = 2'b01
	} seq_state_t;
endpackage

// file: core/vectored_interrupt_controller.sv
`timescale 1ns/1ps
module vectored_interrupt_controller
	import irq_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic [num_sources-1:0] src_event,
	input wire logic instr_done,
	input wire logic enable_irq_instr,
	input wire logic disable_irq_instr,
	input wire logic return_from_irq_instr,
	input wire stack_frame_t cpu_frame,
	input wire stack_frame_t stack_top,
	output logic call_start,
	output logic call_busy,
	output logic [15:0] call_vector,
	output logic stack_push,
	output stack_frame_t push_frame,
	output logic restore_valid,
	output stack_frame_t restore_frame,
	output logic [15:0] fetch_start_addr,
	output logic global_irq_en
);
	// ============================================================
	// Helpers
	// Vector slot of a source; slot zero stays the reset entry
	function automatic logic [15:0] vector_of(input logic [3:0] idx);
		vector_of = vector_base + vector_stride * {12'h000, idx};
	endfunction

	// Fixed chain from vector 1 down; a bus reset beats every other source
	function automatic logic [3:0] pick_first(input logic [num_sources-1:0] req);
		if (req[src_bus_reset]) begin
			pick_first = 4'(src_bus_reset);
		end else if (req[src_timer_128us]) begin
			pick_first = 4'(src_timer_128us);
		end else if (req[src_timer_1ms]) begin
			pick_first = 4'(src_timer_1ms);
		end else if (req[src_addr_a_ep0]) begin
			pick_first = 4'(src_addr_a_ep0);
		end else if (req[src_addr_a_ep1]) begin
			pick_first = 4'(src_addr_a_ep1);
		end else if (req[src_addr_a_ep2]) begin
			pick_first = 4'(src_addr_a_ep2);
		end else if (req[src_addr_b_ep0]) begin
			pick_first = 4'(src_addr_b_ep0);
		end else if (req[src_addr_b_ep1]) begin
			pick_first = 4'(src_addr_b_ep1);
		end else if (req[src_hub]) begin
			pick_first = 4'(src_hub);
		end else if (req[src_dac]) begin
			pick_first = 4'(src_dac);
		end else if (req[src_gpio]) begin
			pick_first = 4'(src_gpio);
		end else if (req[src_i2c]) begin
			pick_first = 4'(src_i2c);
		end else begin
			pick_first = 4'(src_bus_reset);
		end
	endfunction

	// Mask of one source, used to clear only the flag being served
	function automatic logic [num_sources-1:0] onehot_of(input logic [3:0] idx);
		onehot_of = num_sources'(1) << idx;
	endfunction

	// Places a one-bit flag at its position in a status byte
	function automatic logic [7:0] bit_at(input logic flag, input int pos);
		bit_at = 8'(flag) << pos;
	endfunction

	// Only implemented bits are kept; reserved bits always read zero
	function automatic logic [7:0] masked(input logic [7:0] data, input logic [7:0] mask);
		masked = data & mask;
	endfunction

	// ============================================================
	// State
	// Software-visible enables and their next values
	logic [7:0] global_irq_enable;
	logic [7:0] endpoint_irq_enable;
	logic [7:0] next_global_irq_enable;
	logic [7:0] next_endpoint_irq_enable;

	// One flag per source, plus the sense bit and the CPU's global enable
	logic [num_sources-1:0] pending;
	logic irq_sense;
	logic next_irq_sense;
	logic next_global_irq_en;

	// CALL sequencer
	seq_state_t state;
	seq_state_t next_state;
	logic [seq_cnt_w-1:0] seq_cnt;
	logic [seq_cnt_w-1:0] next_seq_cnt;

	// ============================================================
	// Register decode
	wire addr_is_global = reg_req.addr == global_irq_enable_addr;
	wire addr_is_endpoint = reg_req.addr == endpoint_irq_enable_addr;
	wire addr_is_status = reg_req.addr == proc_status_addr;

	wire reg_wr_global = reg_req.wr && addr_is_global;
	wire reg_wr_endpoint = reg_req.wr && addr_is_endpoint;

	// A write replaces the whole field; reserved bits are dropped
	assign next_global_irq_enable = reg_wr_global
		? masked(reg_req.wdata, global_en_mask) : global_irq_enable;
	assign next_endpoint_irq_enable = reg_wr_endpoint
		? masked(reg_req.wdata, endpoint_en_mask) : endpoint_irq_enable;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			global_irq_enable <= global_en_reset;
		end else begin
			global_irq_enable <= next_global_irq_enable;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			endpoint_irq_enable <= endpoint_en_reset;
		end else begin
			endpoint_irq_enable <= next_endpoint_irq_enable;
		end
	end

	// ============================================================
	// Source enables, in vector order
	wire en_bus_reset = global_irq_enable[gen_bus_reset];
	wire en_timer_128us = global_irq_enable[gen_timer_128us];
	wire en_timer_1ms = global_irq_enable[gen_timer_1ms];
	// Endpoint bits run A0, A1, A2, B0, B1 upward from bit zero
	wire [ep_en_count-1:0] en_endpoints = endpoint_irq_enable[ep_en_count-1:0];
	wire en_hub = global_irq_enable[gen_hub];
	// No enable bit exists for the DAC, so its flag is kept but never served
	wire en_dac = 1'b0;
	wire en_gpio = global_irq_enable[gen_gpio];
	wire en_i2c = global_irq_enable[gen_i2c];

	wire [num_sources-1:0] src_enable = {
		en_i2c,
		en_gpio,
		en_dac,
		en_hub,
		en_endpoints,
		en_timer_1ms,
		en_timer_128us,
		en_bus_reset
	};

	// ============================================================
	// Arbitration
	wire [num_sources-1:0] request = pending & src_enable;
	wire any_request = |request;
	wire any_event = |src_event;

	wire seq_idle = state == st_idle;
	// Only at an instruction boundary, so a half-done instruction is never cut
	wire take = seq_idle && instr_done && global_irq_en && any_request;
	wire [3:0] take_idx = pick_first(request);
	wire [num_sources-1:0] take_onehot = take ? onehot_of(take_idx) : '0;

	// Vector of the winner, latched only on a take
	wire [15:0] take_vector = vector_of(take_idx);

	// ============================================================
	// Pending flags
	// A new event beats the service clear of the same flop, so none is lost
	wire [num_sources-1:0] next_pending = (pending & ~take_onehot) | src_event;

	// Reset clears every flag; otherwise only a take does
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pending <= '0;
		end else begin
			pending <= next_pending;
		end
	end

	// ============================================================
	// Global enable
	// Take comes first, since clearing the enable is the first service act;
	// enable and return beat disable when they meet in one cycle
	always_comb begin
		next_global_irq_en = global_irq_en;
		if (take) begin
			next_global_irq_en = 1'b0;
		end else if (return_from_irq_instr || enable_irq_instr) begin
			next_global_irq_en = 1'b1;
		end else if (disable_irq_instr) begin
			next_global_irq_en = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			global_irq_en <= 1'b0;
		end else begin
			global_irq_en <= next_global_irq_en;
		end
	end

	// ============================================================
	// Pending sense
	// Set by any new event, which wins over a take in the same cycle; otherwise a take clears it even if other flags remain
	always_comb begin
		next_irq_sense = irq_sense;
		if (any_event) begin
			next_irq_sense = 1'b1;
		end else if (take) begin
			next_irq_sense = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_sense <= 1'b0;
		end else begin
			irq_sense <= next_irq_sense;
		end
	end

	// ============================================================
	// Automatic CALL sequencer
	// Busy covers the whole CALL, so no second take can start inside it;
	// the table jump that follows is the CPU's own and is not counted here
	wire call_last = seq_cnt == '0;

	always_comb begin
		next_state = state;
		next_seq_cnt = seq_cnt;
		case (state)
			st_idle: begin
				if (take) begin
					next_state = st_call;
					next_seq_cnt = seq_cnt_w'(call_cycles - 1);
				end
			end
			st_call: begin
				if (call_last) begin
					next_state = st_idle;
				end else begin
					next_seq_cnt = seq_cnt - 1'b1;
				end
			end
			default: begin
				next_state = st_idle;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= st_idle;
			seq_cnt <= '0;
		end else begin
			state <= next_state;
			seq_cnt <= next_seq_cnt;
		end
	end

	assign call_busy = state == st_call;

	// ============================================================
	// CPU side outputs
	// Vector and frames hold between events, so the CPU may sample them late
	wire [15:0] next_call_vector = take ? take_vector : call_vector;
	wire stack_frame_t next_push_frame = take ? cpu_frame : push_frame;
	wire stack_frame_t next_restore_frame = return_from_irq_instr ? stack_top : restore_frame;

	// Call and push are one-cycle pulses on the edge after the take
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			call_start <= 1'b0;
		end else begin
			call_start <= take;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stack_push <= 1'b0;
		end else begin
			stack_push <= take;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			call_vector <= reset_vector;
		end else begin
			call_vector <= next_call_vector;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			push_frame <= '0;
		end else begin
			push_frame <= next_push_frame;
		end
	end

	// Return hands back the frame stacked by the matching take
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			restore_valid <= 1'b0;
		end else begin
			restore_valid <= return_from_irq_instr;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			restore_frame <= '0;
		end else begin
			restore_frame <= next_restore_frame;
		end
	end

	// Fetch after any reset starts at the entry ahead of the vectors
	assign fetch_start_addr = reset_vector;

	// ============================================================
	// Register read, one cycle later
	wire [7:0] global_view = masked(global_irq_enable, global_en_mask);
	wire [7:0] endpoint_view = masked(endpoint_irq_enable, endpoint_en_mask);
	// Status byte: only the sense and enable bits are implemented here
	wire [7:0] sense_bit = bit_at(irq_sense, status_pending_bit);
	wire [7:0] enable_bit = bit_at(global_irq_en, status_gie_bit);
	wire [7:0] status_view = sense_bit | enable_bit;

	// Unmapped addresses read zero
	wire [7:0] rd_mux = addr_is_global ? global_view
		: addr_is_endpoint ? endpoint_view
		: addr_is_status ? status_view : 8'h00;
	wire [7:0] next_reg_rdata = reg_req.rd ? rd_mux : 8'h00;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end
endmodule

// file: tb/vic_sva.sv
`timescale 1ns/1ps
module vic_sva
	import irq_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic instr_done,
	input wire logic enable_irq_instr,
	input wire logic disable_irq_instr,
	input wire logic return_from_irq_instr,
	input wire stack_frame_t cpu_frame,
	input wire stack_frame_t stack_top,
	input wire logic call_start,
	input wire logic call_busy,
	input wire logic [15:0] call_vector,
	input wire logic stack_push,
	input wire stack_frame_t push_frame,
	input wire logic restore_valid,
	input wire stack_frame_t restore_frame,
	input wire logic global_irq_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ====
	// Service
	property p_take; call_start |-> $past(instr_done && global_irq_en); endproperty
	a_take: assert property (p_take) else $error("take off boundary");
	property p_busy; call_start |-> call_busy[*8] ##1 call_busy[*2] ##1 !call_busy; endproperty
	a_busy: assert property (p_busy) else $error("call length");
	property p_gie; call_start |-> !global_irq_en; endproperty
	a_gie: assert property (p_gie) else $error("enable kept");
	property p_push; call_start |-> stack_push && push_frame == $past(cpu_frame); endproperty
	a_push: assert property (p_push) else $error("bad push");
	property p_vec; call_start |-> call_vector inside {[16'h0002:16'h0018]} && !call_vector[0];
	endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_ret; return_from_irq_instr |=> restore_valid && restore_frame == $past(stack_top);
	endproperty
	a_ret: assert property (p_ret) else $error("bad restore");
	property p_di; disable_irq_instr && !enable_irq_instr && !return_from_irq_instr |=> !global_irq_en;
	endproperty
	a_di: assert property (p_di) else $error("disable ignored");
	property p_rsv; $past(reg_req.rd && reg_req.addr == 8'h20) |-> !reg_rdata[7] && !reg_rdata[4];
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	c_take: cover property (call_start);
	c_ret: cover property (restore_valid);
	c_rd: cover property (reg_rdata != 8'h00);
endmodule

bind vectored_interrupt_controller vic_sva u_sva (.*);

// file: tb/cpu_seq_model.sv
`timescale 1ns/1ps
module cpu_seq_model
	import irq_ctrl_pkg::*;
#(
	parameter int instr_len = 3
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic call_busy,
	input wire logic stack_push,
	input wire stack_frame_t push_frame,
	input wire logic return_from_irq_instr,
	output logic instr_done,
	output stack_frame_t cpu_frame,
	output stack_frame_t stack_top
);
	stack_frame_t stk [8];
	logic [2:0] sp;
	int cnt;
	assign instr_done = cnt == 0 && !call_busy;
	assign stack_top = stk[sp - 3'd1];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			sp <= 3'd0;
			cpu_frame <= '0;
		end else begin
			// Table jump follows the call before the routine starts
			if (call_busy) cnt <= jump_cycles;
			else if (cnt == 0) cnt <= instr_len - 1;
			else cnt <= cnt - 1;
			if (instr_done) cpu_frame <= {cpu_frame.pc + 16'h0001, ~cpu_frame.carry_flag, 1'b1};
			if (stack_push) begin
				stk[sp] <= push_frame;
				sp <= sp + 3'd1;
			end else if (return_from_irq_instr) sp <= sp - 3'd1;
		end
	end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	import irq_ctrl_pkg::*;
	logic clk = 0;
	logic rst = 1;
	reg_req_t reg_req = '0;
	logic [num_sources-1:0] src_event = '0;
	logic enable_irq_instr = 0;
	logic disable_irq_instr = 0;
	logic return_from_irq_instr = 0;
	logic [7:0] reg_rdata;
	logic instr_done, call_start, call_busy, stack_push, restore_valid, global_irq_en;
	logic [15:0] call_vector, fetch_start_addr;
	stack_frame_t cpu_frame, stack_top, push_frame, restore_frame;
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;
	initial forever #12.5 clk = ~clk;
	vectored_interrupt_controller DUT (.*);
	cpu_seq_model u_cpu (.*);
	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task close_out;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			close_out;
		end
	end
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		reg_req <= '0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		reg_req <= '0;
		#1 check(reg_rdata, exp);
	endtask
	task pulse(input logic [2:0] k);
		@(posedge clk);
		{return_from_irq_instr, disable_irq_instr, enable_irq_instr} <= k;
		@(posedge clk);
		{return_from_irq_instr, disable_irq_instr, enable_irq_instr} <= 3'b000;
	endtask
	task fire(input logic [num_sources-1:0] ev);
		@(posedge clk);
		src_event <= ev;
		@(posedge clk);
		src_event <= '0;
	endtask
	// Waits for a call, compares its vector, then returns from it
	task take(input logic [15:0] exp);
		for (int i = 0; i < 60 && call_start !== 1'b1; i++) @(negedge clk);
		check(call_start === 1'b1 ? call_vector : 16'hFFFF, exp);
		repeat (12) @(negedge clk);
		pulse(3'b100);
	endtask
	task no_take;
		int n;
		n = 0;
		repeat (24) begin
			@(negedge clk);
			n += int'(call_start === 1'b1);
		end
		check(16'(n), 16'h0000);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		rd(8'h20, 8'h00);
		rd(8'h21, 8'h00);
		rd(8'h22, 8'h00);
		check(fetch_start_addr, 16'h0000);
		wr(8'h20, 8'hFF);
		wr(8'h21, 8'hFF);
		rd(8'h20, 8'h6F);
		rd(8'h21, 8'h1F);
		fire('1);
		rd(8'hFF, 8'h80);
		pulse(3'b001);
		for (int v = 0; v < num_sources; v++)
			if (v != src_dac) take(16'h0002 + 16'(2 * v));
		rd(8'hFF, 8'h04);
		wr(8'h20, 8'h00);
		fire(12'h001);
		no_take;
		pulse(3'b010);
		wr(8'h20, 8'h01);
		no_take;
		rd(8'hFF, 8'h80);
		pulse(3'b001);
		take(16'h0002);
		close_out;
	end
endmodule
